// [rtl/digipot_cmd_unit.sv]
// Two-wire command unit of a nonvolatile digital potentiometer with APB status.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ns
// Overview of operation
// [RULE_01] Each command is a 16-bit word shifted in top bit first.
// [RULE_02] Word holds five zero bits, a 3-bit command, then eight data bits.
// [RULE_03] Wiper access drops bit 0 at 64 positions, bits 1:0 at 32. The code keeps every bit of the all-ones code.
// [RULE_04] Command 1 stores the wiper register into nonvolatile memory.
// [RULE_05] Command 2 loads the eight data bits into the wiper register.
// [RULE_06] Command 3 enters shutdown when data bit 0 is 1, leaves when 0.
// [RULE_07] Shutdown opens the upper end and ties the wiper to the lower end.
// [RULE_08] Command 4 reloads the wiper register from memory after the refresh time.
// [RULE_09] Stored value starts at midscale, so first power-up gives midscale.
// [RULE_10] Command 5 selects the wiper register for the next read.
// [RULE_11] Command 6 selects saved wiper (00) or tolerance byte (01).
// [RULE_12] The master writes address, high byte, low byte, then stop.
// [RULE_13] Address of a write and both command bytes are acknowledged.
// [RULE_14] Further byte pairs in one transfer execute in turn.
// [RULE_15] During a store the address is not acknowledged.
// [RULE_16] The master polls the address until it is acknowledged.
// [RULE_17] The master writes a read select, stops, then reads two bytes.
// [RULE_18] A read sends two bytes; no acknowledge stops the second.
// [RULE_19] Each read consumes the selection; another needs a new select.
// [RULE_20] All ones marks bottom scale; the full-scale code marks top scale.
// [RULE_21] A store takes the store time and locks out new commands.
// [RULE_22] After reset the stored value is copied into the wiper register.
// [RULE_23] Command 0 changes nothing.
// [RULE_24] A read returns zero first, then the selected byte.
// [RULE_25] Commands 7 and above are treated as no operation.
module digipot_cmd_unit #(
	parameter int POSITIONS   = digipot_pkg::POSITIONS_DEF,
	parameter int STORE_CYC   = digipot_pkg::STORE_CYCLES,
	parameter int REFRESH_CYC = digipot_pkg::REFRESH_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	output logic [7:0]       wiper_setting_register,
	output logic             shutdown_active,
	output logic             upper_end_open,
	output logic             wiper_to_lower,
	output logic             top_scale,
	output logic             bottom_scale
);
	import digipot_pkg::*;

	localparam logic [7:0] MIDSCALE = 8'(POSITIONS / 2);
	localparam logic [7:0] TOP_CODE = 8'(POSITIONS);

	if (POSITIONS != 128 && POSITIONS != 64 && POSITIONS != 32) begin : g_bad_pos
		$error("digipot_cmd_unit: POSITIONS must be 128, 64 or 32");
	end

	function automatic logic [7:0] mask_wiper(input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (v != BOTTOM_SCALE_CODE) begin
			if (POSITIONS == 64) begin
				r = {v[7:1], 1'b0};
			end else if (POSITIONS == 32) begin
				r = {v[7:2], 2'b00};
			end
		end
		return r;
	endfunction

	line_ev_t    ev;
	port_state_t state;
	logic [3:0]  bit_cnt;
	logic [7:0]  shreg;
	logic [7:0]  hi_byte;
	logic        is_addr;
	logic        rd_mode;
	logic        byte_sel;
	logic        ack_seen;
	logic        word_valid;
	logic        rd_start;
	cmd_word_t   cur_word;
	logic [7:0]  write_value;
	logic [6:0]  slave_addr;
	logic [7:0]  tolerance;
	logic [7:0]  rd_value;
	read_sel_t   rdsel;
	logic        rdsel_valid;
	logic        preset_pending;
	logic        store_req;
	logic        refresh_req;
	logic [7:0]  saved;
	logic        store_busy;
	logic        refresh_busy;
	logic        refresh_done;
	logic        exec;

	line_conditioner u_line (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.ev      (ev)
	);

	nvm_cell #(
		.MIDSCALE    (MIDSCALE),
		.STORE_CYC   (STORE_CYC),
		.REFRESH_CYC (REFRESH_CYC)
	) u_nvm (
		.clk_sys      (clk_sys),
		.rst_n        (rst_n),
		.store_req    (store_req),
		.store_data   (wiper_setting_register),
		.refresh_req  (refresh_req),
		.saved        (saved),
		.store_busy   (store_busy),
		.refresh_busy (refresh_busy),
		.refresh_done (refresh_done)
	);

	assign cur_word    = {hi_byte, shreg}; // see [RULE_01] see [RULE_02]
	assign write_value = mask_wiper(cur_word.data); // see [RULE_03]
	assign exec        = word_valid && !store_busy; // see [RULE_21]

	// Serial port: receives address and byte pairs, acknowledges, sends read data.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state      <= ST_IDLE;
			bit_cnt    <= 4'h0;
			shreg      <= 8'h00;
			hi_byte    <= 8'h00;
			is_addr    <= 1'b0;
			rd_mode    <= 1'b0;
			byte_sel   <= 1'b0;
			ack_seen   <= 1'b0;
			sda_oe     <= 1'b0;
			word_valid <= 1'b0;
			rd_start   <= 1'b0;
		end else begin
			word_valid <= 1'b0;
			rd_start   <= 1'b0;
			if (ev.stop) begin
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
			end else if (ev.start) begin
				state    <= ST_RX;
				bit_cnt  <= 4'h0;
				is_addr  <= 1'b1;
				byte_sel <= 1'b0;
				sda_oe   <= 1'b0;
			end else begin
				case (state)
				ST_RX: begin
					if (ev.scl_rise) begin
						shreg   <= {shreg[6:0], ev.sda}; // see [RULE_01]
						bit_cnt <= 4'(bit_cnt + 4'h1);
					end else if (ev.scl_fall && bit_cnt == 4'h8) begin
						if (is_addr) begin
							if (shreg[7:1] == slave_addr && !store_busy) begin // see [RULE_15]
								state    <= ST_ACK_OUT;
								sda_oe   <= 1'b1; // see [RULE_13]
								rd_mode  <= shreg[0];
								rd_start <= shreg[0];
							end else begin
								state <= ST_IDLE;
							end
						end else begin
							state    <= ST_ACK_OUT;
							sda_oe   <= 1'b1; // see [RULE_13]
							byte_sel <= ~byte_sel; // see [RULE_14]
							if (!byte_sel) begin
								hi_byte <= shreg;
							end else begin
								word_valid <= 1'b1;
							end
						end
					end
				end
				ST_ACK_OUT: begin
					if (ev.scl_fall) begin
						bit_cnt <= 4'h0;
						is_addr <= 1'b0;
						if (rd_mode && is_addr) begin
							state  <= ST_TX;
							shreg  <= READ_FIRST_BYTE; // see [RULE_24]
							sda_oe <= ~READ_FIRST_BYTE[7];
						end else begin
							state  <= ST_RX;
							sda_oe <= 1'b0;
						end
					end
				end
				ST_TX: begin
					if (ev.scl_rise) begin
						bit_cnt <= 4'(bit_cnt + 4'h1);
					end else if (ev.scl_fall) begin
						if (bit_cnt == 4'h8) begin
							state    <= ST_ACK_IN;
							sda_oe   <= 1'b0;
							ack_seen <= 1'b0;
						end else begin
							shreg  <= {shreg[6:0], 1'b0};
							sda_oe <= ~shreg[6];
						end
					end
				end
				ST_ACK_IN: begin
					if (ev.scl_rise) begin
						ack_seen <= ~ev.sda;
					end else if (ev.scl_fall) begin
						if (ack_seen && !byte_sel) begin // see [RULE_18]
							state    <= ST_TX;
							byte_sel <= 1'b1;
							bit_cnt  <= 4'h0;
							shreg    <= rd_value; // see [RULE_24]
							sda_oe   <= ~rd_value[7];
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				default: begin
					state  <= ST_IDLE;
					sda_oe <= 1'b0;
				end
				endcase
			end
		end
	end

	// Wiper register, shutdown state and the memory requests.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wiper_setting_register <= MIDSCALE; // see [RULE_09]
			shutdown_active        <= 1'b0;
			preset_pending         <= 1'b1;
			store_req              <= 1'b0;
			refresh_req            <= 1'b0;
		end else begin
			store_req      <= 1'b0;
			refresh_req    <= 1'b0;
			preset_pending <= 1'b0;
			if (preset_pending || refresh_done) begin
				wiper_setting_register <= saved; // see [RULE_22] see [RULE_08]
			end else if (exec) begin
				case (cur_word.cmd)
				CMD_STORE:    store_req <= 1'b1; // see [RULE_04]
				CMD_WRITE:    wiper_setting_register <= write_value; // see [RULE_05]
				CMD_SHUTDOWN: shutdown_active <= cur_word.data[0]; // see [RULE_06]
				CMD_RESET:    refresh_req <= 1'b1; // see [RULE_08]
				default:      ; // see [RULE_23] see [RULE_25]
				endcase
			end
		end
	end

	// Analog switch controls and scale markers follow the registers.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			upper_end_open <= 1'b0;
			wiper_to_lower <= 1'b0;
			top_scale      <= 1'b0;
			bottom_scale   <= 1'b0;
			sda_out        <= 1'b0;
		end else begin
			upper_end_open <= shutdown_active; // see [RULE_07]
			wiper_to_lower <= shutdown_active; // see [RULE_07]
			bottom_scale   <= wiper_setting_register == BOTTOM_SCALE_CODE; // see [RULE_20]
			top_scale      <= wiper_setting_register == TOP_CODE; // see [RULE_20]
			sda_out        <= 1'b0;
		end
	end

	// Readback selection is armed by a command and consumed by one read.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdsel       <= RSEL_NONE;
			rdsel_valid <= 1'b0;
			rd_value    <= 8'h00;
		end else begin
			if (rd_start) begin
				rdsel_valid <= 1'b0; // see [RULE_19]
				if (!rdsel_valid) begin
					rd_value <= 8'h00;
				end else begin
					case (rdsel)
					RSEL_WIPER: rd_value <= mask_wiper(wiper_setting_register); // see [RULE_03]
					RSEL_SAVED: rd_value <= saved;
					RSEL_TOL:   rd_value <= tolerance;
					default:    rd_value <= 8'h00;
					endcase
				end
			end
			if (exec && cur_word.cmd == CMD_READ_WIPER) begin
				rdsel       <= RSEL_WIPER; // see [RULE_10]
				rdsel_valid <= 1'b1;
			end else if (exec && cur_word.cmd == CMD_READ_NVM) begin
				rdsel_valid <= 1'b1; // see [RULE_11]
				case (cur_word.data[1:0])
				NVM_SEL_SAVED: rdsel <= RSEL_SAVED;
				NVM_SEL_TOL:   rdsel <= RSEL_TOL;
				default:       rdsel <= RSEL_NONE;
				endcase
			end
		end
	end

	// APB slave: zero wait states, read data latched in the setup cycle.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			prdata     <= 32'h0000_0000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			slave_addr <= SLAVE_ADDR_RESET;
			tolerance  <= TOLERANCE_RESET;
		end else begin
			pready <= 1'b1;
			if (psel && !penable) begin
				prdata  <= 32'h0000_0000;
				pslverr <= 1'b0;
				case (paddr)
				ADDR_CONFIG:    prdata[6:0] <= slave_addr;
				ADDR_TOLERANCE: prdata[7:0] <= tolerance;
				ADDR_STATUS: begin
					prdata[7:0]                            <= wiper_setting_register;
					prdata[STATUS_SHUTDOWN]                <= shutdown_active;
					prdata[STATUS_BUSY]                    <= store_busy;
					prdata[STATUS_REFRESH]                 <= refresh_busy;
					prdata[STATUS_SAVED_LSB+7:STATUS_SAVED_LSB] <= saved;
				end
				default: pslverr <= 1'b1;
				endcase
			end
			if (psel && penable && pready && pwrite) begin
				case (paddr)
				ADDR_CONFIG:    slave_addr <= pwdata[6:0];
				ADDR_TOLERANCE: tolerance <= pwdata[7:0];
				default:        ;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_addr_byte_done;
		state == ST_RX && is_addr && ev.scl_fall && bit_cnt == 4'h8;
	endsequence

	sequence s_first_byte_out;
		state == ST_ACK_OUT && ev.scl_fall && rd_mode && is_addr && !ev.start && !ev.stop;
	endsequence

	property p_write_wiper;
		exec && cur_word.cmd == CMD_WRITE && !preset_pending && !refresh_done
			|=> wiper_setting_register == $past(write_value);
	endproperty
	a_write_wiper: assert property (p_write_wiper) else $error("wiper not loaded"); // see [RULE_05]

	property p_shutdown;
		exec && cur_word.cmd == CMD_SHUTDOWN |=> shutdown_active == $past(cur_word.data[0]);
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("shutdown not set"); // see [RULE_06]

	property p_switches;
		shutdown_active |=> upper_end_open && wiper_to_lower;
	endproperty
	a_switches: assert property (p_switches) else $error("switches not in shutdown"); // see [RULE_07]

	property p_store_lock;
		store_req |=> store_busy [*2];
	endproperty
	a_store_lock: assert property (p_store_lock) else $error("store not busy"); // see [RULE_21]

	property p_nack_busy;
		s_addr_byte_done and store_busy and !ev.start and !ev.stop |=> state == ST_IDLE && !sda_oe;
	endproperty
	a_nack_busy: assert property (p_nack_busy) else $error("address acked while busy"); // see [RULE_15]

	property p_addr_ack;
		s_addr_byte_done and shreg[7:1] == slave_addr and !store_busy and !ev.start and !ev.stop
			|=> state == ST_ACK_OUT && sda_oe;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address not acked"); // see [RULE_13]

	property p_refresh;
		refresh_done |=> wiper_setting_register == $past(saved);
	endproperty
	a_refresh: assert property (p_refresh) else $error("refresh did not reload"); // see [RULE_08]

	property p_read_once;
		rd_start && !exec |=> !rdsel_valid;
	endproperty
	a_read_once: assert property (p_read_once) else $error("selection not consumed"); // see [RULE_19]

	property p_no_second;
		state == ST_ACK_IN && ev.scl_fall && !ack_seen && !ev.start && !ev.stop
			|=> state == ST_IDLE && !sda_oe;
	endproperty
	a_no_second: assert property (p_no_second) else $error("second byte after nack"); // see [RULE_18]

	property p_first_zero;
		s_first_byte_out |=> state == ST_TX && sda_oe && shreg == READ_FIRST_BYTE;
	endproperty
	a_first_zero: assert property (p_first_zero) else $error("first byte not zero"); // see [RULE_24]

	property p_preset;
		rst_n && preset_pending |=> wiper_setting_register == $past(saved) && !preset_pending;
	endproperty
	a_preset: assert property (p_preset) else $error("preset missing"); // see [RULE_22]

	property p_nop;
		exec && cur_word.cmd == CMD_NOP && !refresh_done && !preset_pending && !rd_start
			|=> $stable(wiper_setting_register) && $stable(shutdown_active) && $stable(rdsel_valid);
	endproperty
	a_nop: assert property (p_nop) else $error("no-operation changed state"); // see [RULE_23]
endmodule

// [rtl/digipot_pkg.sv]
// Shared constants, types and register map for the potentiometer command unit.
package digipot_pkg;
	localparam int CLK_FREQ_MHZ    = 250;
	localparam int STORE_TIME_MS   = 18;
	localparam int STORE_CYCLES    = STORE_TIME_MS * 1000 * CLK_FREQ_MHZ;
	localparam int REFRESH_TIME_US = 25;
	localparam int REFRESH_CYCLES  = REFRESH_TIME_US * CLK_FREQ_MHZ;
	localparam int POSITIONS_DEF   = 128;
	localparam int WORD_BITS       = 16;

	localparam logic [2:0] CMD_NOP        = 3'h0;
	localparam logic [2:0] CMD_STORE      = 3'h1;
	localparam logic [2:0] CMD_WRITE      = 3'h2;
	localparam logic [2:0] CMD_SHUTDOWN   = 3'h3;
	localparam logic [2:0] CMD_RESET      = 3'h4;
	localparam logic [2:0] CMD_READ_WIPER = 3'h5;
	localparam logic [2:0] CMD_READ_NVM   = 3'h6;

	localparam logic [1:0] NVM_SEL_SAVED = 2'h0;
	localparam logic [1:0] NVM_SEL_TOL   = 2'h1;

	localparam logic [7:0] BOTTOM_SCALE_CODE = 8'hff;
	localparam logic [7:0] READ_FIRST_BYTE   = 8'h00;

	localparam logic [11:0] ADDR_CONFIG    = 12'h000;
	localparam logic [11:0] ADDR_STATUS    = 12'h004;
	localparam logic [11:0] ADDR_TOLERANCE = 12'h008;

	localparam logic [6:0] SLAVE_ADDR_RESET = 7'h2f;
	localparam logic [7:0] TOLERANCE_RESET  = 8'h00;
	localparam int         STATUS_SHUTDOWN  = 8;
	localparam int         STATUS_BUSY      = 9;
	localparam int         STATUS_REFRESH   = 10;
	localparam int         STATUS_SAVED_LSB = 16;

	typedef struct packed {
		logic [4:0] unused;
		logic [2:0] cmd;
		logic [7:0] data;
	} cmd_word_t;

	typedef struct packed {
		logic start;
		logic stop;
		logic scl_rise;
		logic scl_fall;
		logic sda;
	} line_ev_t;

	typedef enum logic [1:0] {
		RSEL_WIPER = 2'b00,
		RSEL_SAVED = 2'b01,
		RSEL_TOL   = 2'b10,
		RSEL_NONE  = 2'b11
	} read_sel_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_RX      = 3'b001,
		ST_ACK_OUT = 3'b010,
		ST_TX      = 3'b011,
		ST_ACK_IN  = 3'b100
	} port_state_t;
endpackage

// [rtl/line_conditioner.sv]
// Synchroniser and start, stop and clock edge detector for the two serial lines.
`timescale 1ns/1ns
module line_conditioner (
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire logic                 scl_in,
	input  wire logic                 sda_in,
	output digipot_pkg::line_ev_t     ev
);
	import digipot_pkg::*;

	logic [2:0] scl_sync;
	logic [2:0] sda_sync;

	// Stage 0 feeds only stage 1; edges are found between stages 1 and 2.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end else begin
			scl_sync <= {scl_sync[1:0], scl_in};
			sda_sync <= {sda_sync[1:0], sda_in};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ev <= '0;
		end else begin
			ev.scl_rise <= scl_sync[1] & ~scl_sync[2];
			ev.scl_fall <= ~scl_sync[1] & scl_sync[2];
			ev.start    <= scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
			ev.stop     <= scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];
			ev.sda      <= sda_sync[1];
		end
	end
endmodule

// [rtl/nvm_cell.sv]
// Nonvolatile wiper store with timed write and timed refresh cycles.
`timescale 1ns/1ns
module nvm_cell #(
	parameter logic [7:0] MIDSCALE    = 8'h40,
	parameter int         STORE_CYC   = digipot_pkg::STORE_CYCLES,
	parameter int         REFRESH_CYC = digipot_pkg::REFRESH_CYCLES
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       store_req,
	input  wire logic [7:0] store_data,
	input  wire logic       refresh_req,
	output logic [7:0]      saved,
	output logic            store_busy,
	output logic            refresh_busy,
	output logic            refresh_done
);
	localparam int CW = $clog2(STORE_CYC + REFRESH_CYC + 1);

	logic [CW-1:0] store_cnt;
	logic [CW-1:0] refresh_cnt;

	if (STORE_CYC < 2 || REFRESH_CYC < 1) begin : g_bad_count
		$error("nvm_cell: store needs at least 2 cycles, refresh at least 1");
	end

	// The value is committed when the write cycle starts; busy then holds for its full length.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			saved      <= MIDSCALE;
			store_busy <= 1'b0;
			store_cnt  <= '0;
		end else if (store_req && !store_busy) begin
			store_busy <= 1'b1;
			store_cnt  <= CW'(STORE_CYC - 1);
			saved      <= store_data;
		end else if (store_busy) begin
			store_cnt <= store_cnt - 1'b1;
			if (store_cnt == '0) begin
				store_busy <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			refresh_busy <= 1'b0;
			refresh_done <= 1'b0;
			refresh_cnt  <= '0;
		end else begin
			refresh_done <= 1'b0;
			if (refresh_req && !refresh_busy) begin
				refresh_busy <= 1'b1;
				refresh_cnt  <= CW'(REFRESH_CYC - 1);
			end else if (refresh_busy) begin
				refresh_cnt <= refresh_cnt - 1'b1;
				if (refresh_cnt == '0) begin
					refresh_busy <= 1'b0;
					refresh_done <= 1'b1;
				end
			end
		end
	end
endmodule

// [verif/i2c_master_model.sv]
// Two-wire bus master model that drives the serial clock and data lines.
`timescale 1ns/1ns
module i2c_master_model (
	input  wire logic clk_sys,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv
);
	initial begin
		scl = 1'h1;
		sda_drv = 1'h1;
	end
	task automatic half();
		repeat (6) @(posedge clk_sys);
	endtask
	// A start is a data fall while the clock is high; the clock stands high between frames.
	task automatic start();
		sda_drv <= 1'h1;
		half();
		sda_drv <= 1'h0;
		half();
		scl <= 1'h0;
	endtask
	task automatic stop();
		@(posedge clk_sys);
		sda_drv <= 1'h0;
		half();
		scl <= 1'h1;
		half();
		sda_drv <= 1'h1;
		half();
	endtask
	// Data changes only while the clock is low; the line is sampled mid high.
	task automatic bit_io(input logic b, output logic r);
		@(posedge clk_sys);
		sda_drv <= b;
		repeat (5) @(posedge clk_sys);
		scl <= 1'h1;
		repeat (3) @(posedge clk_sys);
		r = sda_line;
		repeat (3) @(posedge clk_sys);
		scl <= 1'h0;
	endtask
	// Bytes go top bit first, then the line is released for the acknowledge.
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'h1, r);
		ack = ~r;
	endtask
	// The master acknowledges a read byte by pulling the line low.
	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'h1, r);
			d[i] = r;
		end
		bit_io(~ack, r);
	endtask
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the potentiometer command unit.
`timescale 1ns/1ns
module tb_top;
	import digipot_pkg::*;
	localparam logic [6:0] SADDR = 7'h2f;
	logic        clk_sys = 1'h0;
	logic        rst_n = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, scl, sda_drv, sda_out, sda_oe;
	logic        shutdown_active, upper_end_open, wiper_to_lower, top_scale, bottom_scale;
	logic [7:0]  wiper;
	wire         sda_line;
	int          mismatches = 0;
	int          num_checks = 0;
	always #2 clk_sys = ~clk_sys;
	assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
	digipot_cmd_unit #(.POSITIONS(128), .STORE_CYC(1000), .REFRESH_CYC(20)) i_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.wiper_setting_register(wiper), .shutdown_active(shutdown_active),
		.upper_end_open(upper_end_open), .wiper_to_lower(wiper_to_lower),
		.top_scale(top_scale), .bottom_scale(bottom_scale));
	i2c_master_model i_master (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
		.sda_drv(sda_drv));
	task automatic close_out();
		if (mismatches == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		logic ok;
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'h1 && n < 50);
		ok = (pready === 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk_sys);
		if (!ok) begin
			mismatches++;
			close_out();
		end
	endtask
	task automatic addr(input logic rd, input logic exp_ack);
		logic ack;
		i_master.start();
		i_master.wr_byte({SADDR, rd}, ack);
		chk(ack, exp_ack);
	endtask
	task automatic pair(input logic [2:0] c, input logic [7:0] d);
		cmd_word_t w;
		logic      a1, a2;
		w = '{unused: 5'h00, cmd: c, data: d};
		i_master.wr_byte(w[15:8], a1);
		i_master.wr_byte(w[7:0], a2);
		chk({a1, a2}, 2'h3);
	endtask
	task automatic cmd(input logic [2:0] c, input logic [7:0] d);
		addr(1'h0, 1'h1);
		pair(c, d);
		i_master.stop();
	endtask
	task automatic rd16(input logic ack1, output logic [15:0] v);
		addr(1'h1, 1'h1);
		i_master.rd_byte(1'h1, v[15:8]);
		i_master.rd_byte(ack1, v[7:0]);
		i_master.stop();
	endtask
	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		chk(wiper, 8'h40);
		apb(1'h0, ADDR_STATUS, 32'h0, r, e);
		chk(r, 32'h0040_0040);
		apb(1'h0, ADDR_CONFIG, 32'h0, r, e);
		chk(r, 32'h0000_002f);
		apb(1'h0, ADDR_TOLERANCE, 32'h0, r, e);
		chk(r, 32'h0);
		apb(1'h1, ADDR_TOLERANCE, 32'h52, r, e);
		apb(1'h1, ADDR_STATUS, 32'hffff_ffff, r, e);
		apb(1'h0, ADDR_STATUS, 32'h0, r, e);
		chk(r, 32'h0040_0040);
		apb(1'h0, 12'h00c, 32'h0, r, e);
		chk(e, 1'h1);
		chk(r, 32'h0);
	endtask
	task automatic t_write();
		addr(1'h0, 1'h1);
		pair(CMD_WRITE, 8'h55);
		chk(wiper, 8'h55);
		pair(CMD_WRITE, 8'h80);
		chk({top_scale, bottom_scale}, 2'h2);
		pair(CMD_WRITE, 8'hff);
		chk({wiper, top_scale, bottom_scale}, 10'h3fd);
		pair(CMD_NOP, 8'h12);
		chk(wiper, 8'hff);
		pair(3'h7, 8'h12);
		chk(wiper, 8'hff);
		i_master.stop();
	endtask
	task automatic t_shutdown();
		for (int b = 1; b >= 0; b--) begin
			cmd(CMD_SHUTDOWN, {7'h7f, b[0]});
			chk({shutdown_active, upper_end_open, wiper_to_lower}, {3{b[0]}});
		end
	endtask
	task automatic t_readback();
		logic [15:0] v;
		cmd(CMD_WRITE, 8'h2a);
		cmd(CMD_READ_WIPER, 8'h00);
		rd16(1'h0, v);
		chk(v, 16'h002a);
		rd16(1'h0, v);
		chk(v, 16'h0000);
		cmd(CMD_READ_NVM, 8'h01);
		rd16(1'h0, v);
		chk(v, 16'h0052);
		cmd(CMD_READ_NVM, 8'h00);
		rd16(1'h0, v);
		chk(v, 16'h0040);
		cmd(CMD_READ_WIPER, 8'h00);
		addr(1'h1, 1'h1);
		i_master.rd_byte(1'h0, v[15:8]);
		i_master.rd_byte(1'h0, v[7:0]);
		i_master.stop();
		chk(v, 16'h00ff);
	endtask
	task automatic t_store();
		logic [31:0] r;
		logic [15:0] v;
		logic        e, ack;
		int          n;
		cmd(CMD_WRITE, 8'h33);
		addr(1'h0, 1'h1);
		pair(CMD_STORE, 8'hc5);
		pair(CMD_WRITE, 8'h77);
		i_master.stop();
		chk(wiper, 8'h33);
		apb(1'h0, ADDR_STATUS, 32'h0, r, e);
		chk(r[9], 1'h1);
		addr(1'h0, 1'h0);
		i_master.stop();
		n = 0;
		do begin
			i_master.start();
			i_master.wr_byte({SADDR, 1'h0}, ack);
			i_master.stop();
			n++;
		end while (!ack && n < 20);
		chk(ack, 1'h1);
		if (!ack) begin
			close_out();
		end
		cmd(CMD_READ_NVM, 8'h00);
		rd16(1'h0, v);
		chk(v, 16'h0033);
		cmd(CMD_WRITE, 8'h11);
		cmd(CMD_RESET, 8'h00);
		repeat (30) @(posedge clk_sys);
		chk(wiper, 8'h33);
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk_sys);
		t_reset();
		t_write();
		t_shutdown();
		t_readback();
		t_store();
		close_out();
	end
endmodule
